// *** hdl/flash_status_pkg.sv ***
// Purpose: constants and types for the flash command status flag block
// Assumes: one 25 MHz clock, synchronous active-high reset, AXI4-Lite register access
// Notes:   all fields of the status word sit in byte lane 0
//
// Operation
// - the access error flag reads 0 until an illegal access or sequence violation, then 1.
// - a program or erase attempt on a protected region during a write sequence sets bit 4.
// - writing 1 to bit 4 clears the protection violation flag and writing 0 leaves it alone.
// - while the protection violation flag is set no command launches and no sequence starts.
// - bit 3 reads 1 while a command executes with command-complete low and 0 when idle.
// - bit 2 of the status word is read-only and always reads 0.
// - an error during a command or the reset sequence sets one or more completion status bits.
// - a double fault in the reset sequence may leave completion status off its reset value.
// - writing 1 to bit 7 launches a command and bit 7 stays low until completion or violation.
// - while the access error flag at bit 5 is set launches are ignored; writing 1 clears it.
package flash_status_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int              ADDR_W      = 8;
	localparam logic [7:0]      IDX_STATUS  = 8'h06;
	localparam logic [7:0]      IDX_IRQ_ST  = 8'h08;
	localparam logic [7:0]      IDX_IRQ_MSK = 8'h09;
	localparam logic [ADDR_W-1:0] ADDR_STATUS  = {IDX_STATUS[5:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ST  = {IDX_IRQ_ST[5:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MSK = {IDX_IRQ_MSK[5:0], 2'b00};

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int BIT_CMD_DONE = 7;
	localparam int BIT_RSVD_HI  = 6;
	localparam int BIT_ACC_ERR  = 5;
	localparam int BIT_PROT     = 4;
	localparam int BIT_BUSY     = 3;
	localparam int BIT_RSVD_LO  = 2;
	localparam int STAT_W       = 2;
	localparam int IRQ_DONE     = 0;
	localparam int IRQ_ACC      = 1;
	localparam int IRQ_PROT     = 2;
	localparam int IRQ_W        = 3;

	// ------------------------------------------------------------
	// reset values and bus answers
	// ------------------------------------------------------------
	localparam logic              RST_CMD_DONE  = 1'b1;
	localparam logic [STAT_W-1:0] RST_COMP_STAT = 2'h0;
	localparam logic [IRQ_W-1:0]  RST_IRQ       = 3'h0;
	localparam logic [1:0]        RESP_OKAY     = 2'h0;
	localparam logic [1:0]        RESP_SLVERR   = 2'h2;
	localparam logic [31:0]       ZERO_WORD     = 32'h0000_0000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01
	} ctl_state_t;

	// events from the command sequencer, one-cycle pulses on clk
	typedef struct packed {
		logic              cmd_done;
		logic              cmd_error;
		logic [STAT_W-1:0] cmd_code;
		logic              prot_hit;
		logic              seq_violation;
		logic              rst_seq_done;
		logic [STAT_W-1:0] rst_code;
	} seq_event_t;

	typedef struct packed {
		logic cmd_launch;
		logic seq_start_ok;
	} seq_ctrl_t;

	// sticky flag update: the set wins over a write-one clear
	function automatic logic [IRQ_W-1:0] w1c(input logic [IRQ_W-1:0] cur,
		input logic [IRQ_W-1:0] set, input logic [IRQ_W-1:0] clr);
		w1c = (cur & ~clr) | set;
	endfunction : w1c

endpackage : flash_status_pkg

// *** hdl/flash_command_status_flags.sv ***
// Purpose: status flags of the flash command controller behind an AXI4-Lite slave
// Assumes: sequencer events are synchronous to clk; only byte lane 0 carries fields
// Notes:   one write and one read in flight at a time

`timescale 1ns/100ps

module flash_command_status_flags (
	input  wire logic                                 clk,
	input  wire logic                                 rst,
	input  wire logic [flash_status_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                                 s_axi_awvalid,
	output logic                                      s_axi_awready,
	input  wire logic [31:0]                          s_axi_wdata,
	input  wire logic [3:0]                           s_axi_wstrb,
	input  wire logic                                 s_axi_wvalid,
	output logic                                      s_axi_wready,
	output logic [1:0]                                s_axi_bresp,
	output logic                                      s_axi_bvalid,
	input  wire logic                                 s_axi_bready,
	input  wire logic [flash_status_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                                 s_axi_arvalid,
	output logic                                      s_axi_arready,
	output logic [31:0]                               s_axi_rdata,
	output logic [1:0]                                s_axi_rresp,
	output logic                                      s_axi_rvalid,
	input  wire logic                                 s_axi_rready,
	input  wire flash_status_pkg::seq_event_t         seq_ev,
	output flash_status_pkg::seq_ctrl_t               seq_ctl,
	output logic                                      irq
);
	import flash_status_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic              aw_hold_reg,  aw_hold_next;
	logic [ADDR_W-1:0] awaddr_reg,   awaddr_next;
	logic              w_hold_reg,   w_hold_next;
	logic [31:0]       wdata_reg,    wdata_next;
	logic [3:0]        wstrb_reg,    wstrb_next;
	logic              bvalid_reg,   bvalid_next;
	logic [1:0]        bresp_reg,    bresp_next;
	logic              rvalid_reg,   rvalid_next;
	logic [31:0]       rdata_reg,    rdata_next;
	logic [1:0]        rresp_reg,    rresp_next;
	logic              rd_stat_reg,  rd_stat_next;
	ctl_state_t        state_reg,    state_next;
	logic              cmd_done_reg, cmd_done_next;
	logic              acc_reg,      acc_next;
	logic              prot_reg,     prot_next;
	logic [STAT_W-1:0] comp_reg,     comp_next;
	logic              launch_reg,   launch_next;
	logic [IRQ_W-1:0]  irq_st_reg,   irq_st_next;
	logic [IRQ_W-1:0]  irq_msk_reg,  irq_msk_next;

	logic              do_write;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic              wr_lane0;
	logic              wr_status;
	logic              wr_irq_st;
	logic              wr_irq_msk;
	logic              wr_mapped;
	logic              rd_take;
	logic              busy_flag;
	logic              cmd_end;
	logic              try_launch;
	logic [7:0]        status_word;
	logic [IRQ_W-1:0]  irq_set;

	// ------------------------------------------------------------
	// bus handshakes
	// ------------------------------------------------------------
	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	assign busy_flag = (state_reg == ST_BUSY);
	assign seq_ctl.cmd_launch   = launch_reg;
	assign seq_ctl.seq_start_ok = !prot_reg;
	assign irq = |(irq_st_reg & irq_msk_reg);

	always_comb begin
		status_word               = 8'h00;
		status_word[BIT_CMD_DONE] = cmd_done_reg;
		status_word[BIT_ACC_ERR]  = acc_reg;
		status_word[BIT_PROT]     = prot_reg;
		status_word[BIT_BUSY]     = busy_flag;
		status_word[STAT_W-1:0]   = comp_reg;
		// bits 6 and 2 are left at zero
	end

	always_comb begin
		aw_hold_next = aw_hold_reg;
		awaddr_next  = awaddr_reg;
		w_hold_next  = w_hold_reg;
		wdata_next   = wdata_reg;
		wstrb_next   = wstrb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		rd_stat_next = rd_stat_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_next = 1'b1;
			awaddr_next  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_next = 1'b1;
			wdata_next  = s_axi_wdata;
			wstrb_next  = s_axi_wstrb;
		end
		// the write takes effect in the cycle its last half arrives
		do_write = aw_hold_next && w_hold_next && !bvalid_reg;
		wr_addr  = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
		wr_data  = w_hold_reg ? wdata_reg : s_axi_wdata;
		wr_lane0 = w_hold_reg ? wstrb_reg[0] : s_axi_wstrb[0];
		wr_mapped  = (wr_addr == ADDR_STATUS) || (wr_addr == ADDR_IRQ_ST) ||
			(wr_addr == ADDR_IRQ_MSK);
		wr_status  = do_write && wr_lane0 && (wr_addr == ADDR_STATUS);
		wr_irq_st  = do_write && wr_lane0 && (wr_addr == ADDR_IRQ_ST);
		wr_irq_msk = do_write && wr_lane0 && (wr_addr == ADDR_IRQ_MSK);
		if (do_write) begin
			aw_hold_next = 1'b0;
			w_hold_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		rd_take = s_axi_arvalid && s_axi_arready;
		if (rd_take) begin
			rvalid_next  = 1'b1;
			rresp_next   = RESP_OKAY;
			rd_stat_next = (s_axi_araddr == ADDR_STATUS);
			case (s_axi_araddr)
				ADDR_STATUS: begin
					rdata_next = {24'h00_0000, status_word};
				end
				ADDR_IRQ_ST: begin
					rdata_next = {29'h0000_0000, irq_st_reg};
				end
				ADDR_IRQ_MSK: begin
					rdata_next = {29'h0000_0000, irq_msk_reg};
				end
				default: begin
					rdata_next = ZERO_WORD;
					rresp_next = RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// command flags
	// ------------------------------------------------------------
	always_comb begin
		state_next    = state_reg;
		cmd_done_next = cmd_done_reg;
		comp_next     = comp_reg;
		launch_next   = 1'b0;
		// a violation while busy also ends the command
		cmd_end    = busy_flag && (seq_ev.cmd_done || seq_ev.seq_violation);
		// launch only from idle and only with both error flags clear
		try_launch = wr_status && wr_data[BIT_CMD_DONE] && !busy_flag &&
			!acc_reg && !prot_reg;
		acc_next  = (acc_reg && !(wr_status && wr_data[BIT_ACC_ERR])) ||
			seq_ev.seq_violation;
		prot_next = (prot_reg && !(wr_status && wr_data[BIT_PROT])) ||
			seq_ev.prot_hit;
		case (state_reg)
			ST_IDLE: begin
				if (try_launch) begin
					state_next    = ST_BUSY;
					cmd_done_next = 1'b0;
					comp_next     = RST_COMP_STAT;
					launch_next   = 1'b1;
				end
			end
			ST_BUSY: begin
				if (cmd_end) begin
					state_next    = ST_IDLE;
					cmd_done_next = 1'b1;
					if (seq_ev.cmd_done && seq_ev.cmd_error) begin
						comp_next = seq_ev.cmd_code;
					end
				end
			end
			default: begin
				state_next    = ST_IDLE;
				cmd_done_next = 1'b1;
			end
		endcase
		// a double fault found by the reset sequence lands here
		if (seq_ev.rst_seq_done) begin
			comp_next = seq_ev.rst_code;
		end
	end

	// ------------------------------------------------------------
	// interrupt flags
	// ------------------------------------------------------------
	always_comb begin
		irq_set           = 3'h0;
		irq_set[IRQ_DONE] = cmd_end;
		irq_set[IRQ_ACC]  = seq_ev.seq_violation;
		irq_set[IRQ_PROT] = seq_ev.prot_hit;
		irq_st_next  = w1c(irq_st_reg, irq_set,
			wr_irq_st ? wr_data[IRQ_W-1:0] : RST_IRQ);
		irq_msk_next = wr_irq_msk ? wr_data[IRQ_W-1:0] : irq_msk_reg;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_hold_reg  <= 1'b0;
			awaddr_reg   <= '0;
			w_hold_reg   <= 1'b0;
			wdata_reg    <= ZERO_WORD;
			wstrb_reg    <= 4'h0;
			bvalid_reg   <= 1'b0;
			bresp_reg    <= RESP_OKAY;
			rvalid_reg   <= 1'b0;
			rdata_reg    <= ZERO_WORD;
			rresp_reg    <= RESP_OKAY;
			rd_stat_reg  <= 1'b0;
			state_reg    <= ST_IDLE;
			cmd_done_reg <= RST_CMD_DONE;
			acc_reg      <= 1'b0;
			prot_reg     <= 1'b0;
			comp_reg     <= RST_COMP_STAT;
			launch_reg   <= 1'b0;
			irq_st_reg   <= RST_IRQ;
			irq_msk_reg  <= RST_IRQ;
		end else begin
			aw_hold_reg  <= aw_hold_next;
			awaddr_reg   <= awaddr_next;
			w_hold_reg   <= w_hold_next;
			wdata_reg    <= wdata_next;
			wstrb_reg    <= wstrb_next;
			bvalid_reg   <= bvalid_next;
			bresp_reg    <= bresp_next;
			rvalid_reg   <= rvalid_next;
			rdata_reg    <= rdata_next;
			rresp_reg    <= rresp_next;
			rd_stat_reg  <= rd_stat_next;
			state_reg    <= state_next;
			cmd_done_reg <= cmd_done_next;
			acc_reg      <= acc_next;
			prot_reg     <= prot_next;
			comp_reg     <= comp_next;
			launch_reg   <= launch_next;
			irq_st_reg   <= irq_st_next;
			irq_msk_reg  <= irq_msk_next;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	acc_set_a: assert property (
		seq_ev.seq_violation |=> acc_reg && status_word[BIT_ACC_ERR])
		else $error("access error flag not set after violation");

	acc_quiet_a: assert property (
		!acc_reg && !seq_ev.seq_violation |=> !acc_reg)
		else $error("access error flag set without a violation");

	prot_set_a: assert property (
		seq_ev.prot_hit |=> prot_reg)
		else $error("protection flag not set after protected access");

	prot_quiet_a: assert property (
		!prot_reg && !seq_ev.prot_hit |=> !prot_reg)
		else $error("protection flag set without a protected access");

	prot_hold_a: assert property (
		prot_reg && !(wr_status && wr_data[BIT_PROT]) |=> prot_reg)
		else $error("protection flag lost without a write of one");

	prot_clear_a: assert property (
		prot_reg && wr_status && wr_data[BIT_PROT] && !seq_ev.prot_hit
		|=> !prot_reg)
		else $error("protection flag not cleared by write of one");

	launch_blocked_a: assert property (
		wr_status && wr_data[BIT_CMD_DONE] && (prot_reg || acc_reg)
		|=> !launch_reg && !$fell(cmd_done_reg))
		else $error("command launched while an error flag was set");

	busy_match_a: assert property (
		busy_flag == !cmd_done_reg)
		else $error("busy flag disagrees with command complete");

	zero_bits_a: assert property (
		rvalid_reg && rd_stat_reg
		|-> !rdata_reg[BIT_RSVD_LO] && !rdata_reg[BIT_RSVD_HI])
		else $error("reserved status bit read as one");

	cmd_error_a: assert property (
		busy_flag && seq_ev.cmd_done && seq_ev.cmd_error
		&& !seq_ev.rst_seq_done |=> comp_reg == $past(seq_ev.cmd_code))
		else $error("completion status not loaded on command error");

	rst_status_a: assert property (
		seq_ev.rst_seq_done
		|=> comp_reg == $past(seq_ev.rst_code))
		else $error("reset sequence status not loaded");

	launch_low_a: assert property (
		launch_reg |-> !cmd_done_reg ##1
		(!cmd_done_reg || $past(cmd_end)))
		else $error("command complete rose without command end");

	acc_hold_a: assert property (
		acc_reg && !(wr_status && wr_data[BIT_ACC_ERR]) |=> acc_reg)
		else $error("access error flag lost without a write of one");

	acc_clear_a: assert property (
		acc_reg && wr_status && wr_data[BIT_ACC_ERR] && !seq_ev.seq_violation
		|=> !acc_reg)
		else $error("access error flag not cleared by write of one");

	done_busy_a: assert property (
		busy_flag && seq_ev.cmd_done
		|=> cmd_done_reg && !busy_flag)
		else $error("busy did not drop with command complete");

endmodule : flash_command_status_flags

// *** tb/flash_command_status_flags_tb.sv ***
// Purpose: self-checking bench for the flash command status flag block
// Assumes: AXI4-Lite master driven by non-blocking assignment right after rising edges
// Notes:   sequencer events are single-cycle pulses; expectations come from st()

`timescale 1ns/100ps

`define CHK(got, exp) begin \
	checked++; \
	if ((got) !== (exp)) begin \
		failures++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
	end \
end

module flash_command_status_flags_tb;
	import flash_status_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic              arvalid = 1'b0, rready = 1'b0;
	logic [31:0]       wdata = '0;
	logic [3:0]        wstrb = 4'h0;
	logic [3:0]        strb = 4'hf;
	logic              awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]        bresp, rresp, r, code, rc;
	logic [31:0]       rdata;
	seq_event_t        seq_ev = '0;
	seq_ctrl_t         seq_ctl;
	int                failures = 0;
	int                checked = 0;
	int                launches = 0;
	int                n0;

	always #20 clk = ~clk;

	flash_command_status_flags u_flash_command_status_flags (
		.clk(clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .seq_ev(seq_ev),
		.seq_ctl(seq_ctl), .irq(irq)
	);

	// launch pulses are counted so a refused launch shows as a missing increment
	always @(posedge clk) begin
		if (seq_ctl.cmd_launch === 1'b1)
			launches++;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] st(input logic c, input logic a, input logic p,
		input logic b, input logic [1:0] s);
		st = {24'h00_0000, c, 1'b0, a, p, b, 1'b0, s};
	endfunction : st

	function automatic seq_event_t mk(input logic d, input logic e, input logic [1:0] cc,
		input logic p, input logic v, input logic rs, input logic [1:0] rcc);
		mk = '{d, e, cc, p, v, rs, rcc};
	endfunction : mk

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= strb;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// each channel is released at its own handshake edge
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (!aw_done && awready) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  rs;
		rd(a, d, rs);
		`CHK(d, exp)
		`CHK(rs, er)
	endtask : chk_rd

	task automatic ev(input seq_event_t e);
		@(posedge clk);
		seq_ev <= e;
		@(posedge clk);
		seq_ev <= '0;
	endtask : ev

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim

	// ------------------------------------------------------------
	// watchdog: the whole sequence needs well under 2000 cycles
	// ------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		end_sim();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		void'($urandom(14030));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		chk_rd(ADDR_STATUS, st(1, 0, 0, 0, 0), RESP_OKAY);
		chk_rd(ADDR_IRQ_ST, ZERO_WORD, RESP_OKAY);
		chk_rd(ADDR_IRQ_MSK, ZERO_WORD, RESP_OKAY);
		`CHK(irq, 1'b0)
		`CHK(seq_ctl.seq_start_ok, 1'b1)
		$display("test reset done");

		n0 = launches;
		wr(ADDR_STATUS, 32'h0000_0080, r);
		`CHK(r, RESP_OKAY)
		chk_rd(ADDR_STATUS, st(0, 0, 0, 1, 0), RESP_OKAY);
		`CHK(launches, n0 + 1)
		wr(ADDR_STATUS, 32'h0000_0080, r); // busy: second launch must be refused
		`CHK(launches, n0 + 1)
		code = 2'($urandom()) | 2'h1;
		ev(mk(1, 1, code, 0, 0, 0, 0));
		chk_rd(ADDR_STATUS, st(1, 0, 0, 0, code), RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_STATUS, $urandom() & 32'hffff_ff4f, r);
			chk_rd(ADDR_STATUS, st(1, 0, 0, 0, code), RESP_OKAY);
		end
		$display("test launch done");

		ev(mk(0, 0, 0, 1, 0, 0, 0));
		chk_rd(ADDR_STATUS, st(1, 0, 1, 0, code), RESP_OKAY);
		`CHK(seq_ctl.seq_start_ok, 1'b0)
		n0 = launches;
		wr(ADDR_STATUS, 32'h0000_0080, r);
		chk_rd(ADDR_STATUS, st(1, 0, 1, 0, code), RESP_OKAY);
		`CHK(launches, n0)
		wr(ADDR_STATUS, 32'h0000_0010, r);
		chk_rd(ADDR_STATUS, st(1, 0, 0, 0, code), RESP_OKAY);
		`CHK(seq_ctl.seq_start_ok, 1'b1)
		$display("test protection done");

		ev(mk(0, 0, 0, 0, 1, 0, 0));
		chk_rd(ADDR_STATUS, st(1, 1, 0, 0, code), RESP_OKAY);
		wr(ADDR_STATUS, 32'h0000_0080, r);
		chk_rd(ADDR_STATUS, st(1, 1, 0, 0, code), RESP_OKAY);
		`CHK(launches, n0)
		wr(ADDR_STATUS, 32'h0000_0020, r);
		chk_rd(ADDR_STATUS, st(1, 0, 0, 0, code), RESP_OKAY);
		wr(ADDR_STATUS, 32'h0000_0080, r);
		chk_rd(ADDR_STATUS, st(0, 0, 0, 1, 0), RESP_OKAY);
		ev(mk(0, 0, 0, 0, 1, 0, 0)); // a violation mid-command ends it
		chk_rd(ADDR_STATUS, st(1, 1, 0, 0, 0), RESP_OKAY);
		wr(ADDR_STATUS, 32'h0000_0020, r);
		$display("test access error done");

		chk_rd(ADDR_IRQ_ST, 32'h0000_0007, RESP_OKAY);
		`CHK(irq, 1'b0)
		wr(ADDR_IRQ_MSK, 32'h0000_0002, r);
		`CHK(irq, 1'b1)
		wr(ADDR_IRQ_ST, 32'h0000_0002, r);
		`CHK(irq, 1'b0)
		wr(ADDR_IRQ_MSK, 32'h0000_0007, r);
		`CHK(irq, 1'b1)
		wr(ADDR_IRQ_ST, 32'h0000_0005, r);
		`CHK(irq, 1'b0)
		chk_rd(ADDR_IRQ_ST, ZERO_WORD, RESP_OKAY);
		$display("test interrupt done");

		rc = 2'($urandom()) | 2'h2;
		ev(mk(0, 0, 0, 0, 0, 1, rc));
		chk_rd(ADDR_STATUS, st(1, 0, 0, 0, rc), RESP_OKAY);
		chk_rd(8'h04, ZERO_WORD, RESP_SLVERR);
		wr(8'h04, 32'h0000_0080, r);
		`CHK(r, RESP_SLVERR)
		chk_rd(ADDR_STATUS, st(1, 0, 0, 0, rc), RESP_OKAY);
		$display("test reset sequence and unmapped done");

		n0 = launches;
		strb = 4'he;
		wr(ADDR_STATUS, 32'h0000_0080, r); // lane 0 off: the launch is ignored
		strb = 4'hf;
		`CHK(r, RESP_OKAY)
		`CHK(launches, n0)
		wr(ADDR_STATUS, 32'h0000_0080, r);
		ev(mk(0, 0, 0, 1, 0, 0, 0)); // a protection hit does not end a command
		chk_rd(ADDR_STATUS, st(0, 0, 1, 1, 0), RESP_OKAY);
		`CHK(launches, n0 + 1)
		ev(mk(1, 0, code, 0, 0, 0, 0));
		chk_rd(ADDR_STATUS, st(1, 0, 1, 0, 0), RESP_OKAY);
		wr(ADDR_IRQ_MSK, 32'h0000_0007, r);
		`CHK(irq, 1'b1)
		$display("test lane and busy protection done");

		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		chk_rd(ADDR_STATUS, st(1, 0, 0, 0, 0), RESP_OKAY);
		chk_rd(ADDR_IRQ_ST, ZERO_WORD, RESP_OKAY);
		chk_rd(ADDR_IRQ_MSK, ZERO_WORD, RESP_OKAY);
		`CHK(irq, 1'b0)
		`CHK(seq_ctl.seq_start_ok, 1'b1)
		$display("test mid-run reset done");
		end_sim();
	end

endmodule : flash_command_status_flags_tb
